/* apb_host.sv */
`timescale 1ns/100ps
module apb_host
(
  input wire logic clk,
  input wire logic go,
  input wire logic wrReq,
  input wire logic [11:0] addrReq,
  input wire logic [31:0] dataReq,
  output logic [11:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic done,
  output logic [31:0] rdata,
  output logic err
);
  initial
  begin
    {paddr, psel, penable, pwrite, pwdata, done, rdata, err} = '0;
  end
  // Released write data is inverted so a late sample cannot pass
  always @(posedge clk)
  begin
    done <= 1'b0;
    if (psel && penable && pready)
    begin
      rdata <= prdata;
      err <= pslverr;
      done <= 1'b1;
      {psel, penable} <= 2'b00;
      pwdata <= ~pwdata;
    end
    else if (psel)
      penable <= 1'b1;
    else if (go)
    begin
      psel <= 1'b1;
      paddr <= addrReq;
      pwrite <= wrReq;
      pwdata <= dataReq;
    end
  end
endmodule : apb_host

/* event_log.sv */
`timescale 1ns/100ps
// Notes on behaviour
// R01: Tag in byte 0 bits 4:0
// R02: Byte 0 bit 7 marks non-queued error
// R03: Bytes 1-13 snapshot shadow registers; the code keeps bytes 1 and 11 zero
// R04: Byte 511 makes page sum zero
// R05: Power-up reset zeroes all counters
// R06: Link and software resets keep counters
// R07: BIST Activate FIS clears all counters
// R08: Page 11h feature bit 0: return, clear
// R09: Entry is 16-bit identifier then value
// R10: Identifier bit 15 reserved, zero
// R11: Bits 14:12 give counter width
// R12: Width codes 1,2,3,4 mean 16..64 bits
// R13: Transmitted is outbound, received inbound
// R14: Identifier zero terminates the list
// R15: 001h counts ICRC command failures
// R16: 002h-007h count R_ERR responses by kind
// R17: 009h counts ready to not-ready drops
// R18: 00Ah counts COMRESET signature FISes
// R19: 00Bh received CRC, 00Dh other errors
// R20: Four zero bytes, list, zeros, checksum
// R21: Counters saturate instead of wrapping
module event_log
  import event_log_pkg::*;
#(
  parameter int ADDR_WIDTH = 12
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic icrcFail,
  input wire logic rerrDataD2h,
  input wire logic rerrDataH2d,
  input wire logic rerrNonDataD2h,
  input wire logic rerrNonDataH2d,
  input wire logic linkReadyState,
  input wire logic sigFisComreset,
  input wire logic rxCrcError,
  input wire logic rxOtherError,
  input wire logic bistActivate,
  input wire logic errCapture,
  input wire logic nonqueuedErrorFlag,
  input wire logic [4:0] errTag,
  input wire logic [7:0] shadowStatus,
  input wire logic [7:0] shadowError,
  input wire logic [7:0] shadowLbaLow,
  input wire logic [7:0] shadowLbaMid,
  input wire logic [7:0] shadowLbaHigh,
  input wire logic [7:0] shadowDevice,
  input wire logic [7:0] shadowLbaLowPrev,
  input wire logic [7:0] shadowLbaMidPrev,
  input wire logic [7:0] shadowLbaHighPrev,
  input wire logic [7:0] shadowCount,
  input wire logic [7:0] shadowCountPrev
);

  if (ADDR_WIDTH < 10 || ADDR_WIDTH > 12)
  begin : g_check
    $error("event_log: ADDR_WIDTH must be 10 to 12");
  end

  // The byte mux hard-codes these positions, so a package edit that moves
  // them must stop the build rather than produce a silently wrong page.
  if (CKSUM_BYTE != PAGE_BYTES - 1 || TERM_BYTE != LIST_START + 4 * NUM_CNT)
  begin : g_layout_check
    $error("event_log: page layout constants disagree");
  end

  if (CNT_WIDTH != 16 || NQ_BIT != 7 || TAG_MSB != 4 || CMD_SNAP_BYTES > 16)
  begin : g_field_check
    $error("event_log: field constants do not match the logic");
  end

  // Only plain 16-bit entries fit the four-byte slots of the page
  for (genvar g = 0; g < NUM_CNT; g++)
  begin : g_id_check
    if (CNT_IDS[g][ID_RESERVED_BIT] != 1'b0 || CNT_IDS[g][ID_WIDTH_LSB +: 3] != WIDTH_CODE_16)
    begin : g_bad_id
      $error("event_log: counter identifier is not a 16-bit entry"); // see R10, R12
    end
  end

  function automatic logic [15:0] satInc(input logic [15:0] val);
    satInc = (val == CNT_MAX) ? val : 16'(val + 16'h0001); // see R21
  endfunction : satInc

  logic [15:0] cnt_q [NUM_CNT];
  logic [15:0] cntSnap_q [NUM_CNT];
  logic [7:0] errRec_q [CMD_SNAP_BYTES];
  logic [7:0] cmdSnap_q [CMD_SNAP_BYTES];
  logic [NUM_CNT-1:0] evt;
  logic linkReadyPrev_q;
  logic errLogged_q;
  logic unsupported_q;
  logic [31:0] cmd_q;
  page_type pageSel_q;
  logic readyQ;
  logic errQ;
  logic [31:0] prdata_q;
  logic [7:0] evtCksum;
  logic [7:0] cmdCksum;
  logic [11:0] addr;
  logic access;
  logic done;
  logic cmdWrite;
  logic [7:0] cmdPage;
  logic cmdFeature;
  logic clearNow;
  logic pageHit;
  logic mapped;
  logic [31:0] readWord;

  assign addr = 12'(paddr);
  assign access = psel & penable & ~readyQ;
  assign done = psel & penable & readyQ;
  assign pageHit = (addr <= ADDR_PAGE_LAST) && (addr[1:0] == 2'b00) && ~pwrite;
  assign mapped = pageHit || addr == ADDR_CMD || (addr == ADDR_STATUS && ~pwrite);
  assign cmdWrite = done & pwrite & (addr == ADDR_CMD) & ~errQ;
  assign cmdPage = pstrb[0] ? pwdata[7:0] : cmd_q[7:0];
  assign cmdFeature = pstrb[1] ? pwdata[CMD_FEAT_BIT] : cmd_q[CMD_FEAT_BIT];

  // Page 11h read with feature bit 0 clears after the snapshot is taken
  assign clearNow = bistActivate // see R07
    | (cmdWrite & (cmdPage == LOG_EVENT) & cmdFeature); // see R08

  // Event decode; direction names follow the drive's view of the link
  always_comb
  begin
    evt = '0;
    evt[CNT_ICRC] = icrcFail; // see R15
    evt[CNT_RERR_DATA] = rerrDataD2h | rerrDataH2d; // see R16
    evt[CNT_RERR_DATA_D2H] = rerrDataD2h; // see R13
    evt[CNT_RERR_DATA_H2D] = rerrDataH2d; // see R13
    evt[CNT_RERR_NDATA] = rerrNonDataD2h | rerrNonDataH2d; // see R16
    evt[CNT_RERR_NDATA_D2H] = rerrNonDataD2h;
    evt[CNT_RERR_NDATA_H2D] = rerrNonDataH2d;
    evt[CNT_LINK_DROP] = linkReadyPrev_q & ~linkReadyState; // see R17
    evt[CNT_SIG_FIS] = sigFisComreset; // see R18
    evt[CNT_RX_CRC] = rxCrcError; // see R19
    evt[CNT_RX_OTHER] = rxOtherError; // see R19
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      linkReadyPrev_q <= 1'b0;
    end
    else
    begin
      linkReadyPrev_q <= linkReadyState;
    end
  end

  // Of the resets only the power-up reset zeroes the counters; link and soft resets
  // never reach this block, so values survive them.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      for (int k = 0; k < NUM_CNT; k++)
      begin
        cnt_q[k] <= '0; // see R05
      end
    end
    else
    begin
      for (int k = 0; k < NUM_CNT; k++)
      begin
        if (clearNow)
        begin
          // An event in the clearing cycle is kept
          cnt_q[k] <= {15'h0000, evt[k]}; // see R07
        end
        else if (evt[k])
        begin
          cnt_q[k] <= satInc(cnt_q[k]); // see R06
        end
      end
    end
  end

  // Error record, captured when the error is reported
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      for (int k = 0; k < CMD_SNAP_BYTES; k++)
      begin
        errRec_q[k] <= 8'h00;
      end
      errLogged_q <= 1'b0;
    end
    else if (errCapture)
    begin
      errRec_q[0] <= {nonqueuedErrorFlag, 2'b00, errTag}; // see R01, R02
      errRec_q[1] <= 8'h00;
      errRec_q[2] <= shadowStatus; // see R03
      errRec_q[3] <= shadowError;
      errRec_q[4] <= shadowLbaLow;
      errRec_q[5] <= shadowLbaMid;
      errRec_q[6] <= shadowLbaHigh;
      errRec_q[7] <= shadowDevice;
      errRec_q[8] <= shadowLbaLowPrev;
      errRec_q[9] <= shadowLbaMidPrev;
      errRec_q[10] <= shadowLbaHighPrev;
      errRec_q[11] <= 8'h00;
      errRec_q[12] <= shadowCount;
      errRec_q[13] <= shadowCountPrev;
      errLogged_q <= 1'b1;
    end
  end

  // Page snapshot on command; the reader sees a stable page even while
  // events and new errors keep arriving.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pageSel_q <= PAGE_NONE;
      unsupported_q <= 1'b0;
      cmd_q <= CMD_RESET;
      for (int k = 0; k < NUM_CNT; k++)
      begin
        cntSnap_q[k] <= '0;
      end
      for (int k = 0; k < CMD_SNAP_BYTES; k++)
      begin
        cmdSnap_q[k] <= 8'h00;
      end
    end
    else if (cmdWrite)
    begin
      cmd_q <= {23'h000000, cmdFeature, cmdPage};
      unsupported_q <= 1'b0;
      if (cmdPage == LOG_EVENT)
      begin
        pageSel_q <= PAGE_EVT;
        for (int k = 0; k < NUM_CNT; k++)
        begin
          cntSnap_q[k] <= cnt_q[k]; // see R08
        end
      end
      else if (cmdPage == LOG_CMD_ERR)
      begin
        pageSel_q <= PAGE_CMD;
        for (int k = 0; k < CMD_SNAP_BYTES; k++)
        begin
          cmdSnap_q[k] <= errRec_q[k];
        end
      end
      else
      begin
        pageSel_q <= PAGE_NONE;
        unsupported_q <= 1'b1;
      end
    end
  end

  // Checksums over the stored fields; every other byte is zero
  always_comb
  begin
    logic [7:0] sumE;
    logic [7:0] sumC;
    sumE = 8'h00;
    sumC = 8'h00;
    for (int k = 0; k < NUM_CNT; k++)
    begin
      sumE = 8'(sumE + CNT_IDS[k][7:0] + CNT_IDS[k][15:8]);
      sumE = 8'(sumE + cntSnap_q[k][7:0] + cntSnap_q[k][15:8]);
    end
    for (int k = 0; k < CMD_SNAP_BYTES; k++)
    begin
      sumC = 8'(sumC + cmdSnap_q[k]);
    end
    evtCksum = 8'(8'h00 - sumE); // see R04
    cmdCksum = 8'(8'h00 - sumC); // see R04
  end

  function automatic logic [7:0] pageByte(input logic [8:0] idx);
    logic [8:0] rel;
    logic [3:0] ent;
    rel = 9'(idx - 9'(LIST_START));
    ent = rel[5:2];
    pageByte = 8'h00;
    unique case (pageSel_q)
      PAGE_EVT:
      begin
        if (idx == 9'(CKSUM_BYTE))
        begin
          pageByte = evtCksum;
        end
        // Bytes 0-3, the zero identifier at 48-49 and 50-510 stay zero
        else if (idx >= 9'(LIST_START) && idx < 9'(TERM_BYTE)) // see R20, R14
        begin
          unique case (rel[1:0])
            2'b00: pageByte = CNT_IDS[ent][7:0]; // see R09
            2'b01: pageByte = CNT_IDS[ent][15:8]; // see R10, R11, R12
            2'b10: pageByte = cntSnap_q[ent][7:0];
            2'b11: pageByte = cntSnap_q[ent][15:8];
          endcase
        end
      end
      PAGE_CMD:
      begin
        if (idx == 9'(CKSUM_BYTE))
        begin
          pageByte = cmdCksum;
        end
        else if (idx < 9'(CMD_SNAP_BYTES))
        begin
          pageByte = cmdSnap_q[idx[3:0]]; // see R03
        end
      end
      PAGE_NONE:
      begin
        pageByte = 8'h00;
      end
    endcase
  endfunction : pageByte

  always_comb
  begin
    readWord = 32'h0000_0000;
    if (pageHit)
    begin
      for (int b = 0; b < 4; b++)
      begin
        readWord[8*b +: 8] = pageByte({addr[8:2], 2'(b)});
      end
    end
    else if (addr == ADDR_CMD)
    begin
      readWord = cmd_q;
    end
    else if (addr == ADDR_STATUS)
    begin
      readWord[ST_PAGE_CMD] = (pageSel_q == PAGE_CMD);
      readWord[ST_PAGE_EVT] = (pageSel_q == PAGE_EVT);
      readWord[ST_ERR_LOGGED] = errLogged_q;
      readWord[ST_LINK_READY] = linkReadyState;
      readWord[ST_UNSUPPORTED] = unsupported_q;
    end
  end

  // One wait state: the page word is formed from flops in the first
  // access cycle and presented from a register in the second.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      readyQ <= 1'b0;
      errQ <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      readyQ <= access;
      if (access)
      begin
        errQ <= ~mapped;
        prdata_q <= (pwrite || !mapped) ? 32'h0000_0000 : readWord;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = readyQ;
  assign pslverr = readyQ & errQ;

endmodule : event_log

/* event_log_asserts.sv */
`timescale 1ns/100ps
module event_log_asserts
  import event_log_pkg::*;
#(
  parameter int ADDR_WIDTH = 12
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  wire acc = psel && penable;
  a_one_wait: assert property ($rose(acc) |-> !pready ##1 pready)
    else $error("pready not after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_ready_access: assert property (pready |-> acc)
    else $error("pready outside access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_unmapped_err: assert property (pready && paddr > ADDR_STATUS |-> pslverr)
    else $error("unmapped access accepted");
  a_window_ro: assert property (pready && pwrite && paddr <= ADDR_PAGE_LAST |-> pslverr)
    else $error("page window write accepted");
  a_unaligned_err: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("unaligned access accepted");
  a_cmd_ok: assert property (pready && paddr == ADDR_CMD |-> !pslverr)
    else $error("command access refused");
  a_rdata_hold: assert property (!psel |=> $stable(prdata))
    else $error("prdata changed while idle");
  a_reset_zero: assert property (disable iff (1'b0) !rst_n |=> !pready && prdata == 32'h0)
    else $error("outputs not cleared by reset");
endmodule : event_log_asserts

bind event_log event_log_asserts #(.ADDR_WIDTH(ADDR_WIDTH)) chk (.clk, .rst_n, .paddr,
  .psel, .penable, .pwrite, .prdata, .pready, .pslverr);

/* event_log_pkg.sv */
package event_log_pkg;

  // Page geometry
  localparam int PAGE_BYTES = 512;
  localparam int CKSUM_BYTE = 511;
  localparam int NUM_CNT = 11;
  localparam int LIST_START = 4;
  localparam int TERM_BYTE = 48;
  localparam int CMD_SNAP_BYTES = 14;

  // Counter identifier layout
  localparam int ID_RESERVED_BIT = 15;
  localparam int ID_WIDTH_LSB = 12;
  localparam logic [2:0] WIDTH_CODE_16 = 3'h1;
  localparam logic [2:0] WIDTH_CODE_32 = 3'h2;
  localparam logic [2:0] WIDTH_CODE_48 = 3'h3;
  localparam logic [2:0] WIDTH_CODE_64 = 3'h4;
  localparam int CNT_WIDTH = 16;
  localparam logic [15:0] CNT_MAX = 16'hffff;

  // Identifier words in ascending order, all 16-bit counters
  localparam logic [15:0] CNT_IDS [NUM_CNT] = '{
    {1'b0, WIDTH_CODE_16, 12'h001}, {1'b0, WIDTH_CODE_16, 12'h002},
    {1'b0, WIDTH_CODE_16, 12'h003}, {1'b0, WIDTH_CODE_16, 12'h004},
    {1'b0, WIDTH_CODE_16, 12'h005}, {1'b0, WIDTH_CODE_16, 12'h006},
    {1'b0, WIDTH_CODE_16, 12'h007}, {1'b0, WIDTH_CODE_16, 12'h009},
    {1'b0, WIDTH_CODE_16, 12'h00a}, {1'b0, WIDTH_CODE_16, 12'h00b},
    {1'b0, WIDTH_CODE_16, 12'h00d}};

  // Counter slots
  localparam int CNT_ICRC = 0;
  localparam int CNT_RERR_DATA = 1;
  localparam int CNT_RERR_DATA_D2H = 2;
  localparam int CNT_RERR_DATA_H2D = 3;
  localparam int CNT_RERR_NDATA = 4;
  localparam int CNT_RERR_NDATA_D2H = 5;
  localparam int CNT_RERR_NDATA_H2D = 6;
  localparam int CNT_LINK_DROP = 7;
  localparam int CNT_SIG_FIS = 8;
  localparam int CNT_RX_CRC = 9;
  localparam int CNT_RX_OTHER = 10;

  // Log page numbers
  localparam logic [7:0] LOG_CMD_ERR = 8'h10;
  localparam logic [7:0] LOG_EVENT = 8'h11;

  // Command error page byte 0 bit positions
  localparam int NQ_BIT = 7;
  localparam int TAG_MSB = 4;

  // APB map
  localparam logic [11:0] ADDR_PAGE_LAST = 12'h1fc;
  localparam logic [11:0] ADDR_CMD = 12'h200;
  localparam logic [11:0] ADDR_STATUS = 12'h204;
  localparam int CMD_FEAT_BIT = 8;
  localparam logic [31:0] CMD_RESET = 32'h0000_0000;
  localparam int ST_PAGE_CMD = 0;
  localparam int ST_PAGE_EVT = 1;
  localparam int ST_ERR_LOGGED = 2;
  localparam int ST_LINK_READY = 3;
  localparam int ST_UNSUPPORTED = 4;

  typedef enum logic [2:0] {
    PAGE_NONE = 3'b001,
    PAGE_CMD = 3'b010,
    PAGE_EVT = 3'b100
  } page_type;

endpackage : event_log_pkg

/* tb_top.sv */
`timescale 1ns/100ps
module tb_top
  import event_log_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n, psel, penable, pwrite, pready, pslverr, go, wrReq, done, err, nq;
  logic [11:0] paddr, addrReq;
  logic [31:0] pwdata, prdata, dataReq, rdata;
  logic [10:0] ev;
  logic [4:0] tag;
  logic [7:0] sh [11];
  logic [15:0] cv [11];
  logic [31:0] epg [128];
  logic [11:0] ids [11] = '{12'h001, 12'h002, 12'h003, 12'h004, 12'h005, 12'h006,
    12'h007, 12'h009, 12'h00a, 12'h00b, 12'h00d};
  int failures = 0;
  int compares = 0;
  always #2 clk = ~clk;
  apb_host host (.clk, .go, .wrReq, .addrReq, .dataReq, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .done, .rdata, .err);
  event_log dut (.clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb(4'hf),
    .prdata, .pready, .pslverr, .icrcFail(ev[0]), .rerrDataD2h(ev[1]), .rerrDataH2d(ev[2]),
    .rerrNonDataD2h(ev[3]), .rerrNonDataH2d(ev[4]), .linkReadyState(!ev[5]),
    .sigFisComreset(ev[6]), .rxCrcError(ev[7]), .rxOtherError(ev[8]), .bistActivate(ev[9]),
    .errCapture(ev[10]), .nonqueuedErrorFlag(nq), .errTag(tag), .shadowStatus(sh[0]),
    .shadowError(sh[1]), .shadowLbaLow(sh[2]), .shadowLbaMid(sh[3]), .shadowLbaHigh(sh[4]),
    .shadowDevice(sh[5]), .shadowLbaLowPrev(sh[6]), .shadowLbaMidPrev(sh[7]),
    .shadowLbaHighPrev(sh[8]), .shadowCount(sh[9]), .shadowCountPrev(sh[10]));
  task automatic test_done;
    if (failures == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Done is read at the edge after it rose, so no race with its update
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    {wrReq, addrReq, dataReq, go} <= {w, a, d, 1'b1};
    @(posedge clk);
    go <= 1'b0;
    do @(posedge clk); while (done !== 1'b1);
  endtask : bus
  task automatic pulse(input int b, input int n);
    repeat (n)
    begin
      ev[b] <= 1'b1;
      @(posedge clk);
      ev[b] <= 1'b0;
      @(posedge clk);
    end
  endtask : pulse
  task automatic page(input string nm);
    logic [7:0] s;
    s = 8'h0;
    for (int i = 0; i < 511; i++) s += epg[i/4][8*(i%4) +: 8];
    epg[127][31:24] = -s;
    for (int w = 0; w < 128; w++)
    begin
      bus(1'b0, 12'(4*w), 32'h0);
      chk(nm, epg[w], rdata);
    end
  endtask : page
  task automatic evpage(input string nm);
    epg = '{default: 32'h0};
    for (int k = 0; k < 11; k++) epg[1+k] = {cv[k], 16'h1000 | 16'(ids[k])};
    page(nm);
  endtask : evpage
  task automatic t_count;
    for (int b = 0; b < 9; b++) pulse(b, b % 3 + 1);
    // Data and non-data kinds also feed the 002h and 005h totals
    cv = '{16'h1, 16'h5, 16'h2, 16'h3, 16'h3, 16'h1, 16'h2, 16'h3, 16'h1, 16'h2, 16'h3};
    bus(1'b1, ADDR_CMD, 32'h111);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk("status", 32'h0a, rdata);
    evpage("event page");
    cv = '{default: 16'h0};
    bus(1'b1, ADDR_CMD, 32'h011);
    evpage("after read clear");
  endtask : t_count
  task automatic t_clear;
    pulse(0, 2);
    pulse(7, 1);
    ev <= 11'h201;
    @(posedge clk);
    ev <= 11'h0;
    @(posedge clk);
    cv[0] = 16'h1;
    bus(1'b1, ADDR_CMD, 32'h011);
    evpage("after bist");
    pulse(1, 1);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    cv[0] = 16'h0;
    bus(1'b1, ADDR_CMD, 32'h011);
    evpage("after power up");
  endtask : t_clear
  task automatic t_err;
    for (int n = 0; n < 2; n++)
    begin
      foreach (sh[i]) sh[i] <= 8'(8'h30 + 16 * n + i);
      nq <= n[0];
      tag <= 5'(5'h11 + 13 * n);
      pulse(10, 1);
      bus(1'b1, ADDR_CMD, {24'h0, LOG_CMD_ERR});
      epg = '{default: 32'h0};
      epg[0] = {sh[1], sh[0], 8'h0, nq, 2'b00, tag};
      epg[1] = {sh[5], sh[4], sh[3], sh[2]};
      epg[2] = {8'h0, sh[8], sh[7], sh[6]};
      epg[3] = {16'h0, sh[10], sh[9]};
      page("error page");
    end
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk("status error page", 32'h0d, rdata);
  endtask : t_err
  task automatic t_refuse;
    bus(1'b1, ADDR_CMD, 32'h012);
    bus(1'b1, 12'h000, 32'h1234);
    chk("window write err", 32'h1, {31'h0, err});
    bus(1'b0, 12'h208, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    bus(1'b0, 12'h002, 32'h0);
    chk("unaligned err", 32'h1, {31'h0, err});
    bus(1'b0, ADDR_CMD, 32'h0);
    chk("cmd readback", 32'h012, rdata);
    chk("cmd readback err", 32'h0, {31'h0, err});
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk("status unsupported", 32'h1c, rdata);
    epg = '{default: 32'h0};
    page("unsupported page");
  endtask : t_refuse
  task automatic t_sat;
    ev[0] <= 1'b1;
    repeat (65540) @(posedge clk);
    ev[0] <= 1'b0;
    @(posedge clk);
    cv[0] = 16'hffff;
    bus(1'b1, ADDR_CMD, 32'h011);
    evpage("saturated");
  endtask : t_sat
  initial
  begin
    {rst_n, ev, nq, tag, go, wrReq, addrReq, dataReq} = '0;
    foreach (sh[i]) sh[i] = 8'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_count;
    t_clear;
    t_err;
    t_refuse;
    t_sat;
    test_done;
  end
  initial
  begin
    #360000;
    failures++;
    test_done;
  end
endmodule : tb_top
